// ---- bench/lsc_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsc_regs_tb;
    import lsc_pkg::*;
    localparam int NL = 12;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic tx_al = 1'b0;
    logic rx_al = 1'b0;
    logic [NL-1:0] blk = '0;
    logic [NL-1:0] mfs = '0;
    logic [NL-1:0] crc = '0;
    logic fifo_err = 1'b0;
    logic lock_ref;
    logic [NL-1:0] inj;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    int cnt [NL];
    logic [DATA_W-1:0] v;

    lsc_regs #(.NUM_LANES(NL)) dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WR_DATA(wdata), .WR_EN(wr_en),
        .RD_EN(rd_en), .RD_DATA(rdata), .IRQ(irq), .TX_ALIGNED(tx_al), .RX_ALIGNED(rx_al), .BLOCK_LOCK(blk),
        .MF_SYNC(mfs), .CRC_ERR(crc), .TX_FIFO_ERR(fifo_err), .RX_LOCK_TO_REF(lock_ref), .TX_CRC_INJECT(inj));

    // ==========================================================
    // clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    // ==========================================================
    // bus tasks and comparisons
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // read data is sampled just after the edge that follows the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] g;
        rd(a, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t addr=%h got=%h exp=%h", $time, a, g, e);
        end
    endtask

    task automatic chk_pin(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t pin got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // packs the modelled counters of one counter register
    function automatic logic [DATA_W-1:0] exp_crc(input int r);
        logic [DATA_W-1:0] x;
        x = '0;
        for (int l = 0; l < LANES_PER_REG; l++) begin
            if (r * 8 + l < NL) x[4*l +: 4] = cnt[r*8+l][3:0];
        end
        return x;
    endfunction

    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // tests
    initial begin
        void'($urandom(19));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        chk_rd(OFS_RST_CTRL, '0);
        chk_rd(OFS_INJECT, '0);
        chk_rd(16'h0040, '0); // unmapped place reads zero
        chk_pin({31'h0, irq}, '0);
        $display("test reset done");

        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            {tx_al, rx_al} <= 2'($urandom);
            blk <= NL'($urandom);
            mfs <= NL'($urandom);
            waitc(6);
            chk_rd(OFS_ALIGN_ST, {30'h0, rx_al, tx_al});
            chk_rd(OFS_BLK_LOCK, DATA_W'(blk));
            chk_rd(OFS_MF_SYNC, DATA_W'(mfs));
        end
        $display("test status done");

        wr(OFS_RST_CTRL, 32'h0000_0100);
        waitc(1);
        chk_pin({31'h0, lock_ref}, 32'h1);
        chk_rd(OFS_RST_CTRL, 32'h0000_0100);
        wr(OFS_RST_CTRL, '0);
        waitc(1);
        chk_pin({31'h0, lock_ref}, '0);
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            wr(OFS_INJECT, v);
            waitc(1);
            chk_pin(DATA_W'(inj), DATA_W'(v[NL-1:0]));
        end
        wr(OFS_ALIGN_ST, 32'h3);
        chk_rd(OFS_ALIGN_ST, {30'h0, rx_al, tx_al});
        $display("test control done");

        // start from cleared counters; the pulses below are held off while the clear bit stands
        wr(OFS_RST_CTRL, 32'h0000_0040);
        @(posedge clk);
        crc <= '1;
        @(posedge clk);
        crc <= '0;
        chk_rd(OFS_CRC_CNT0, '0);
        wr(OFS_RST_CTRL, '0);
        foreach (cnt[l]) cnt[l] = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            v = $urandom;
            v[0] = (i < 20); // lane 0 is driven past saturation
            crc <= v[NL-1:0];
            foreach (cnt[l]) if (v[l] && cnt[l] < 15) cnt[l]++;
        end
        @(posedge clk);
        crc <= '0;
        for (int r = 0; r < 4; r++) chk_rd(OFS_CRC_CNT0 + ADDR_W'(r), exp_crc(r));
        wr(OFS_RST_CTRL, 32'h0000_0040);
        wr(OFS_RST_CTRL, '0);
        foreach (cnt[l]) cnt[l] = 0;
        chk_rd(OFS_CRC_CNT1, '0);
        $display("test counters done");

        @(posedge clk);
        tx_al <= 1'b1;
        rx_al <= 1'b1;
        waitc(6);
        wr(OFS_RST_CTRL, 32'h0000_00c0);
        wr(OFS_RST_CTRL, '0);
        chk_rd(OFS_RX_STAT, '0);
        chk_rd(OFS_TX_STAT, '0);
        @(posedge clk);
        rx_al <= 1'b0;
        waitc(6);
        @(posedge clk);
        rx_al <= 1'b1;
        waitc(6);
        chk_rd(OFS_RX_STAT, 32'h1);
        @(posedge clk);
        fifo_err <= 1'b1;
        @(posedge clk);
        fifo_err <= 1'b0;
        chk_rd(OFS_TX_STAT, 32'h1);
        wr(OFS_RST_CTRL, 32'h0000_0040);
        wr(OFS_RST_CTRL, '0);
        chk_rd(OFS_RX_STAT, '0);
        chk_rd(OFS_TX_STAT, 32'h1);
        wr(OFS_RST_CTRL, 32'h0000_0080);
        wr(OFS_RST_CTRL, '0);
        chk_rd(OFS_TX_STAT, '0);
        @(posedge clk);
        tx_al <= 1'b0;
        waitc(6);
        chk_rd(OFS_TX_STAT, 32'h1);
        @(posedge clk);
        tx_al <= 1'b1;
        waitc(6);
        $display("test sticky done");

        chk_rd(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_MASK, 32'h4);
        chk_rd(OFS_IRQ_MASK, 32'h4);
        chk_pin({31'h0, irq}, '0);
        @(posedge clk);
        crc <= 12'h008;
        @(posedge clk);
        crc <= '0;
        waitc(2);
        chk_pin({31'h0, irq}, 32'h1);
        chk_rd(OFS_IRQ_STAT, 32'h4);
        waitc(2);
        chk_pin({31'h0, irq}, '0);
        wr(OFS_IRQ_MASK, '0);
        @(posedge clk);
        crc <= 12'h008;
        @(posedge clk);
        crc <= '0;
        waitc(3);
        chk_pin({31'h0, irq}, '0);
        chk_rd(OFS_CRC_CNT0, 32'h0000_2000);
        $display("test interrupt done");
        end_sim();
    end
endmodule // lsc_regs_tb
`default_nettype wire

// ---- hw/lsc_pkg.sv ----
`default_nettype none
package lsc_pkg;
    // ==========================================================
    // bus shape
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned MAX_LANES = 32;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned LANES_PER_REG = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;

    // ==========================================================
    // register offsets (register index, one word each)
    localparam logic [ADDR_W-1:0] OFS_RST_CTRL = 16'h0013;
    localparam logic [ADDR_W-1:0] OFS_ALIGN_ST = 16'h0020;
    localparam logic [ADDR_W-1:0] OFS_BLK_LOCK = 16'h0021;
    localparam logic [ADDR_W-1:0] OFS_MF_SYNC = 16'h0022;
    localparam logic [ADDR_W-1:0] OFS_CRC_CNT0 = 16'h0023;
    localparam logic [ADDR_W-1:0] OFS_CRC_CNT1 = 16'h0024;
    localparam logic [ADDR_W-1:0] OFS_CRC_CNT2 = 16'h0025;
    localparam logic [ADDR_W-1:0] OFS_CRC_CNT3 = 16'h0026;
    localparam logic [ADDR_W-1:0] OFS_RX_STAT = 16'h0027;
    localparam logic [ADDR_W-1:0] OFS_TX_STAT = 16'h0028;
    localparam logic [ADDR_W-1:0] OFS_INJECT = 16'h0029;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 16'h0030;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 16'h0031;

    // ==========================================================
    // field positions
    localparam int unsigned BIT_LOCK_REF = 8;
    localparam int unsigned BIT_TX_CLR = 7;
    localparam int unsigned BIT_RX_CLR = 6;
    localparam int unsigned BIT_TX_ALIGNED = 0;
    localparam int unsigned BIT_RX_ALIGNED = 1;
    localparam int unsigned BIT_LOSS = 0;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RX_LOSS = 0;
    localparam int unsigned IRQ_TX_LOSS = 1;
    localparam int unsigned IRQ_CRC_ERR = 2;
endpackage
`default_nettype wire

// ---- hw/lsc_regs.sv ----
// Functional notes
// - writing 1 to control bit 7 clears the transmit sticky flag.
// - writing 1 to control bit 6 clears receive CRC counters and the receive sticky flag.
// - control bit 8 forces receive transceivers into lock-to-reference mode.
// - alignment status bit 0 reads 1 while transmit lanes are aligned.
// - alignment status bit 1 reads 1 while receive lanes are aligned.
// - block-lock register shows one bit per lane, 1 once boundaries found.
// - sync register shows one bit per lane, 1 once metaframe sync achieved.
// - one 4-bit CRC error counter per receive lane, saturating at f.
// - CRC counters packed eight lanes per register, lanes 7:0 first.
// - receive status bit 0 sticks on receive alignment loss until cleared.
// - transmit status bit 0 sticks on transmit alignment loss or FIFO fault.
// - each set injection bit corrupts CRC32 on its transmit lane.
`timescale 1ns/1ns
`default_nettype none
module lsc_regs #(
    parameter int unsigned NUM_LANES = 12
) (
    input wire logic CLK, // 50 MHz clock
    input wire logic RESETN, // async reset, active low
    input wire logic [lsc_pkg::ADDR_W-1:0] ADDR, // register index
    input wire logic [lsc_pkg::DATA_W-1:0] WR_DATA, // write data
    input wire logic WR_EN, // write strobe
    input wire logic RD_EN, // read strobe
    output logic [lsc_pkg::DATA_W-1:0] RD_DATA, // read data, cycle after RD_EN
    output logic IRQ, // level interrupt
    input wire logic TX_ALIGNED, // transmit lanes aligned, async level
    input wire logic RX_ALIGNED, // receive lanes aligned, async level
    input wire logic [NUM_LANES-1:0] BLOCK_LOCK, // per-lane boundary lock, async
    input wire logic [NUM_LANES-1:0] MF_SYNC, // per-lane metaframe sync, async
    input wire logic [NUM_LANES-1:0] CRC_ERR, // per-lane CRC error pulse
    input wire logic TX_FIFO_ERR, // transmit FIFO under/overflow pulse
    output logic RX_LOCK_TO_REF, // force receive lock to reference
    output logic [NUM_LANES-1:0] TX_CRC_INJECT // per-lane CRC32 corruption
);
    import lsc_pkg::*;

    // ==========================================================
    // declarations
    logic [1:0] align_s;
    logic [NUM_LANES-1:0] blk_lock_s;
    logic [NUM_LANES-1:0] mf_sync_s;
    logic [1:0] align_d_r;
    logic [CNT_W*MAX_LANES-1:0] crc_cnt;
    logic [DATA_W-1:0] ctrl_r;
    logic [NUM_LANES-1:0] inject_r;
    logic rx_loss_r;
    logic tx_loss_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_ev;
    logic [DATA_W-1:0] rd_nxt;
    logic tx_clr;
    logic rx_clr;
    logic rx_fell;
    logic tx_fell;

    // ==========================================================
    // synchronisers for transceiver status levels
    lsc_sync3 #(.W(2)) u_sync_align (
        .CLK(CLK),
        .RESETN(RESETN),
        .d({RX_ALIGNED, TX_ALIGNED}),
        .q(align_s)
    );

    lsc_sync3 #(.W(2*NUM_LANES)) u_sync_lane (
        .CLK(CLK),
        .RESETN(RESETN),
        .d({MF_SYNC, BLOCK_LOCK}),
        .q({mf_sync_s, blk_lock_s})
    );

    // ==========================================================
    // control register
    assign tx_clr = ctrl_r[BIT_TX_CLR];
    assign rx_clr = ctrl_r[BIT_RX_CLR];

    // only the documented bits are stored; others read as zero
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r <= '0;
        end else if (WR_EN && ADDR == OFS_RST_CTRL) begin
            ctrl_r <= '0;
            ctrl_r[BIT_LOCK_REF] <= WR_DATA[BIT_LOCK_REF];
            ctrl_r[BIT_TX_CLR] <= WR_DATA[BIT_TX_CLR];
            ctrl_r[BIT_RX_CLR] <= WR_DATA[BIT_RX_CLR];
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RX_LOCK_TO_REF <= 1'b0;
        end else if (WR_EN && ADDR == OFS_RST_CTRL) begin
            RX_LOCK_TO_REF <= WR_DATA[BIT_LOCK_REF];
        end
    end

    // ==========================================================
    // error injection
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            inject_r <= '0;
        end else if (WR_EN && ADDR == OFS_INJECT) begin
            inject_r <= WR_DATA[NUM_LANES-1:0];
        end
    end

    // register and output updated together so readback matches the lanes
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            TX_CRC_INJECT <= '0;
        end else if (WR_EN && ADDR == OFS_INJECT) begin
            TX_CRC_INJECT <= WR_DATA[NUM_LANES-1:0];
        end
    end

    // ==========================================================
    // per-lane saturating CRC error counters, zero above NUM_LANES
    genvar gi;
    generate
        for (gi = 0; gi < MAX_LANES; gi++) begin : g_lane
            if (gi < NUM_LANES) begin : g_on
                lsc_sat_cnt u_cnt (
                    .CLK(CLK),
                    .RESETN(RESETN),
                    .inc(CRC_ERR[gi]),
                    .clr(rx_clr),
                    .count(crc_cnt[gi*CNT_W +: CNT_W])
                );
            end else begin : g_off
                assign crc_cnt[gi*CNT_W +: CNT_W] = '0;
            end
        end
    endgenerate

    // ==========================================================
    // sticky alignment-loss flags
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            align_d_r <= '0;
        end else begin
            align_d_r <= align_s;
        end
    end

    assign rx_fell = align_d_r[BIT_RX_ALIGNED] & ~align_s[BIT_RX_ALIGNED];
    assign tx_fell = align_d_r[BIT_TX_ALIGNED] & ~align_s[BIT_TX_ALIGNED];

    // a held clear keeps the flag at zero, so clear beats a new loss here
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_loss_r <= 1'b0;
        end else if (rx_clr) begin
            rx_loss_r <= 1'b0;
        end else if (rx_fell) begin
            rx_loss_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_loss_r <= 1'b0;
        end else if (tx_clr) begin
            tx_loss_r <= 1'b0;
        end else if (tx_fell || TX_FIFO_ERR) begin
            tx_loss_r <= 1'b1;
        end
    end

    // ==========================================================
    // interrupt status, mask and output
    always_comb begin
        irq_ev = '0;
        irq_ev[IRQ_RX_LOSS] = rx_fell;
        irq_ev[IRQ_TX_LOSS] = tx_fell | TX_FIFO_ERR;
        irq_ev[IRQ_CRC_ERR] = |CRC_ERR;
    end

    // a new event in the read-clear cycle survives the clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_stat_r <= '0;
        end else if (RD_EN && ADDR == OFS_IRQ_STAT) begin
            irq_stat_r <= irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_mask_r <= '0;
        end else if (WR_EN && ADDR == OFS_IRQ_MASK) begin
            irq_mask_r <= WR_DATA[IRQ_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ==========================================================
    // read decode
    always_comb begin
        rd_nxt = '0;
        if (ADDR == OFS_RST_CTRL) begin
            rd_nxt = ctrl_r;
        end else if (ADDR == OFS_ALIGN_ST) begin
            rd_nxt[BIT_TX_ALIGNED] = align_s[BIT_TX_ALIGNED];
            rd_nxt[BIT_RX_ALIGNED] = align_s[BIT_RX_ALIGNED];
        end else if (ADDR == OFS_BLK_LOCK) begin
            rd_nxt[NUM_LANES-1:0] = blk_lock_s;
        end else if (ADDR == OFS_MF_SYNC) begin
            rd_nxt[NUM_LANES-1:0] = mf_sync_s;
        end else if (ADDR == OFS_CRC_CNT0) begin
            rd_nxt = crc_cnt[0*DATA_W +: DATA_W];
        end else if (ADDR == OFS_CRC_CNT1) begin
            rd_nxt = crc_cnt[1*DATA_W +: DATA_W];
        end else if (ADDR == OFS_CRC_CNT2) begin
            rd_nxt = crc_cnt[2*DATA_W +: DATA_W];
        end else if (ADDR == OFS_CRC_CNT3) begin
            rd_nxt = crc_cnt[3*DATA_W +: DATA_W];
        end else if (ADDR == OFS_RX_STAT) begin
            rd_nxt[BIT_LOSS] = rx_loss_r;
        end else if (ADDR == OFS_TX_STAT) begin
            rd_nxt[BIT_LOSS] = tx_loss_r;
        end else if (ADDR == OFS_INJECT) begin
            rd_nxt[NUM_LANES-1:0] = inject_r;
        end else if (ADDR == OFS_IRQ_STAT) begin
            rd_nxt[IRQ_W-1:0] = irq_stat_r;
        end else if (ADDR == OFS_IRQ_MASK) begin
            rd_nxt[IRQ_W-1:0] = irq_mask_r;
        end
    end

    // data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RD_DATA <= '0;
        end else if (RD_EN) begin
            RD_DATA <= rd_nxt;
        end else begin
            RD_DATA <= '0;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    AST_TX_CLEAR: assert property (
        tx_clr |=> !tx_loss_r)
        else $error("transmit sticky flag not cleared");

    AST_RX_CLEAR: assert property (
        rx_clr |=> (!rx_loss_r && crc_cnt == '0))
        else $error("receive counters or flag not cleared");

    AST_HOLD_CLEAR: assert property (
        rx_clr && !(WR_EN && ADDR == OFS_RST_CTRL) |=> rx_clr ##1 crc_cnt == '0)
        else $error("held clear did not keep counters at zero");

    AST_LOCK_REF: assert property (
        WR_EN && ADDR == OFS_RST_CTRL |=> RX_LOCK_TO_REF == $past(WR_DATA[BIT_LOCK_REF]))
        else $error("lock-to-reference output does not follow write");

    AST_ALIGN_READ: assert property (
        RD_EN && ADDR == OFS_ALIGN_ST |=> RD_DATA[1:0] == $past(align_s) && RD_DATA[DATA_W-1:2] == '0)
        else $error("alignment status read mismatch");

    AST_LOCK_READ: assert property (
        RD_EN && ADDR == OFS_BLK_LOCK |=> RD_DATA[NUM_LANES-1:0] == $past(blk_lock_s))
        else $error("block lock read mismatch");

    AST_SYNC_READ: assert property (
        RD_EN && ADDR == OFS_MF_SYNC |=> RD_DATA[NUM_LANES-1:0] == $past(mf_sync_s))
        else $error("metaframe sync read mismatch");

    AST_CRC_COUNT: assert property (
        CRC_ERR[0] && !rx_clr && crc_cnt[CNT_W-1:0] != CNT_MAX
        |=> crc_cnt[CNT_W-1:0] == $past(crc_cnt[CNT_W-1:0]) + 4'h1)
        else $error("lane 0 counter did not step");

    AST_CRC_SAT: assert property (
        !rx_clr && crc_cnt[CNT_W-1:0] == CNT_MAX |=> crc_cnt[CNT_W-1:0] == CNT_MAX)
        else $error("lane 0 counter wrapped");

    AST_CRC_PACK: assert property (
        RD_EN && ADDR == OFS_CRC_CNT0 |=> RD_DATA[CNT_W-1:0] == $past(crc_cnt[CNT_W-1:0]))
        else $error("counter packing mismatch");

    AST_RX_STICKY: assert property (
        rx_fell && !rx_clr && !(WR_EN && ADDR == OFS_RST_CTRL && WR_DATA[BIT_RX_CLR]) |=> rx_loss_r [*2])
        else $error("receive loss not sticky");

    AST_TX_STICKY: assert property (
        TX_FIFO_ERR && !tx_clr |=> tx_loss_r)
        else $error("transmit loss flag not set");

    AST_INJECT: assert property (
        WR_EN && ADDR == OFS_INJECT |=> TX_CRC_INJECT == $past(WR_DATA[NUM_LANES-1:0]))
        else $error("injection output does not follow write");
endmodule // lsc_regs
`default_nettype wire

// ---- hw/lsc_sat_cnt.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsc_sat_cnt (
    input wire logic CLK, // clock
    input wire logic RESETN, // async reset, active low
    input wire logic inc, // one error seen this cycle
    input wire logic clr, // hold at zero while high
    output logic [lsc_pkg::CNT_W-1:0] count // saturating count
);
    import lsc_pkg::*;

    // ==========================================================
    // clear dominates so a held clear keeps the count at zero
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            count <= '0;
        end else if (clr) begin
            count <= '0;
        end else if (inc && count != CNT_MAX) begin
            count <= count + 4'h1;
        end
    end
endmodule // lsc_sat_cnt
`default_nettype wire

// ---- hw/lsc_sync3.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsc_sync3 #(
    parameter int unsigned W = 1
) (
    input wire logic CLK, // clock
    input wire logic RESETN, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous level in
    output logic [W-1:0] q // filtered level out
);
    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;

    // ==========================================================
    // three stages; a bit moves only when stages two and three agree
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ff1_r <= '0;
            ff2_r <= '0;
            ff3_r <= '0;
        end else begin
            ff1_r <= d;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= '0;
        end else begin
            q <= (ff2_r & ff3_r) | (q & (ff2_r | ff3_r));
        end
    end
endmodule // lsc_sync3
`default_nettype wire
